// ==== fps_sequencer.sv ====
// host-side program/erase sequencer for a parallel nor flash, apb slave
// ***********************************************************
// Summary of operation
// - program setup uses 40h or 10h
// - second write carries data and address
// - re-strobe output enable for each status poll
// - wait for ready bit before checking errors
// - write FFh to return to read array
// - supply low must be cleared before program/erase
// - erase is 20h then D0h in block
// - suspend B0h, poll ready, read suspended bit
// - suspended: read array, other blocks only
// - sticky flags allow deferred error checking
// - resume with D0h clears suspended state
// ***********************************************************
`timescale 1ns/1ps
module fps_sequencer (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   output logic [16:0]      flAddr,
   output logic [15:0]      flDqOut,
   output logic             flDqOe,
   input  wire logic [15:0] flDqIn,
   output logic             flCeN,
   output logic             flOeN,
   output logic             flWeN,
   output logic             flByteN,
   output logic             flRpN
);
   typedef struct packed {
      fps_pkg::fps_state_type st;
      logic [7:0]  cnt;
      logic [2:0]  op;
      logic        wrIdx;
      logic        twoWr;
      logic        poll;
      logic        tail;
      logic [15:0] word0;
      logic [15:0] word1;
      logic        busy;
      logic [16:0] addr;
      logic [15:0] data;
      logic        wordMode;
      logic        rpN;
      logic        progFail;
      logic        eraseFail;
      logic        supplyLow;
      logic        suspended;
      logic        suspReq;
      logic        seqErr;
      logic [16:0] suspAddr;
      logic [7:0]  lastStat;
      logic [15:0] rdData;
      logic [2:0]  irqStat;
      logic [2:0]  irqMask;
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
      logic        irq;
      logic [16:0] flAddr;
      logic [15:0] dqOut;
      logic        dqOe;
      logic        ceN;
      logic        oeN;
      logic        weN;
   } fps_regs_type;

   fps_regs_type r;
   fps_regs_type next_r;
   logic [15:0]  dqSync;
   logic         apbAcc;
   logic         goReq;
   logic         refuse;
   logic [2:0]   reqOp;

   fps_pin_sync #(.W(16)) u_dq_sync (
      .clk    (clk),
      .rst_n  (rst_n),
      .pinIn  (flDqIn),
      .pinOut (dqSync)
   );

   // ***********************************************************
   // request decode
   // ***********************************************************
   assign apbAcc = psel & penable & r.pready;
   assign goReq  = apbAcc & pwrite & (paddr == fps_pkg::ADDR_CTRL);
   assign reqOp  = pwdata[fps_pkg::CTRL_OP_LSB +: 3];

   always_comb begin
      // a running erase still takes a suspend; it lands between polls
      refuse = r.busy && !(reqOp == fps_pkg::OP_SUSPEND && r.op == fps_pkg::OP_ERASE);
      if (r.supplyLow && (reqOp == fps_pkg::OP_PROG || reqOp == fps_pkg::OP_ERASE)) begin
         refuse = 1'b1;
      end
      if (r.suspended && (reqOp == fps_pkg::OP_PROG || reqOp == fps_pkg::OP_ERASE ||
                          reqOp == fps_pkg::OP_SUSPEND || reqOp == fps_pkg::OP_CLEAR)) begin
         refuse = 1'b1;
      end
      if (r.suspended && reqOp == fps_pkg::OP_READ &&
          r.addr[16:fps_pkg::BLOCK_LSB] == r.suspAddr[16:fps_pkg::BLOCK_LSB]) begin
         refuse = 1'b1;
      end
   end

   // ***********************************************************
   // next state
   // ***********************************************************
   always_comb begin
      logic [2:0] ev;
      logic [7:0] sb;
      ev       = '0;
      sb       = r.lastStat;
      next_r   = r;
      // apb: answer one cycle into the access phase
      next_r.pready  = psel & penable & ~r.pready;
      next_r.pslverr = 1'b0;
      next_r.prdata  = '0;
      if (psel && penable && !r.pready) begin
         unique case (paddr)
            fps_pkg::ADDR_CTRL:     next_r.prdata = {29'h0, r.op};
            fps_pkg::ADDR_ADDR:     next_r.prdata = {15'h0, r.addr};
            fps_pkg::ADDR_DATA:     next_r.prdata = {16'h0, r.rdData};
            fps_pkg::ADDR_STATUS:   next_r.prdata = {16'h0, r.lastStat, 2'h0, r.seqErr, r.suspended,
                                                     r.supplyLow, r.eraseFail, r.progFail, r.busy};
            fps_pkg::ADDR_IRQ_STAT: next_r.prdata = {29'h0, r.irqStat};
            fps_pkg::ADDR_IRQ_MASK: next_r.prdata = {29'h0, r.irqMask};
            fps_pkg::ADDR_CFG:      next_r.prdata = {30'h0, ~r.rpN, r.wordMode};
            default:                next_r.pslverr = 1'b1;
         endcase
      end
      if (apbAcc && pwrite) begin
         unique case (paddr)
            fps_pkg::ADDR_ADDR:     next_r.addr = pwdata[16:0];
            fps_pkg::ADDR_DATA:     next_r.data = pwdata[15:0];
            fps_pkg::ADDR_IRQ_MASK: next_r.irqMask = pwdata[2:0];
            fps_pkg::ADDR_CFG: begin
               next_r.wordMode = pwdata[fps_pkg::CFG_WORD];
               next_r.rpN      = ~pwdata[fps_pkg::CFG_PDOWN];
            end
            default: ;
         endcase
      end
      // operation launch
      if (goReq) begin
         if (refuse) begin
            ev[fps_pkg::IRQ_REFUSED] = 1'b1;
         end else if (r.busy) begin
            next_r.suspReq = 1'b1;
         end else begin
            next_r.op    = reqOp;
            next_r.busy  = 1'b1;
            next_r.wrIdx = 1'b0;
            next_r.twoWr = 1'b0;
            next_r.poll  = 1'b0;
            next_r.tail  = 1'b0;
            next_r.word1 = 16'h0000;
            next_r.st    = fps_pkg::S_WSET;
            unique case (reqOp)
               fps_pkg::OP_READ: begin
                  next_r.st  = fps_pkg::S_RPUL;
                  next_r.cnt = fps_pkg::ACC_CYC;
               end
               fps_pkg::OP_PROG: begin
                  next_r.word0 = {8'h00, pwdata[fps_pkg::CTRL_ALT] ? fps_pkg::CMD_PROG_SETUP_ALT
                                                                    : fps_pkg::CMD_PROG_SETUP};
                  next_r.word1 = r.data;
                  next_r.twoWr = 1'b1;
                  next_r.poll  = 1'b1;
               end
               fps_pkg::OP_ERASE: begin
                  next_r.word0 = {8'h00, fps_pkg::CMD_ERASE_SETUP};
                  next_r.word1 = {8'h00, fps_pkg::CMD_CONFIRM};
                  next_r.twoWr = 1'b1;
                  next_r.poll  = 1'b1;
               end
               fps_pkg::OP_SUSPEND: begin
                  next_r.word0 = {8'h00, fps_pkg::CMD_SUSPEND};
                  next_r.poll  = 1'b1;
                  next_r.tail  = 1'b1;
               end
               fps_pkg::OP_RESUME: next_r.word0 = {8'h00, fps_pkg::CMD_CONFIRM};
               fps_pkg::OP_CLEAR: begin
                  next_r.word0     = {8'h00, fps_pkg::CMD_CLEAR_STATUS};
                  next_r.progFail  = 1'b0;
                  next_r.eraseFail = 1'b0;
                  next_r.supplyLow = 1'b0;
                  next_r.seqErr    = 1'b0;
               end
               fps_pkg::OP_ARRAY:  next_r.word0 = {2{fps_pkg::CMD_READ_ARRAY}};
               fps_pkg::OP_STATUS: next_r.word0 = {8'h00, fps_pkg::CMD_READ_STATUS};
            endcase
         end
      end
      // ***********************************************************
      // flash bus cycles
      // ***********************************************************
      unique case (r.st)
         fps_pkg::S_IDLE: ;
         fps_pkg::S_WSET: begin
            next_r.ceN    = 1'b0;
            next_r.dqOe   = 1'b1;
            next_r.flAddr = r.addr;
            next_r.dqOut  = r.wrIdx ? r.word1 : r.word0;
            next_r.cnt    = fps_pkg::WP_CYC;
            next_r.weN    = 1'b0;
            next_r.st     = fps_pkg::S_WPUL;
         end
         fps_pkg::S_WPUL: begin
            next_r.cnt = r.cnt - 8'h01;
            if (r.cnt == 8'h01) begin
               next_r.weN = 1'b1;
               next_r.cnt = fps_pkg::REC_CYC;
               next_r.st  = fps_pkg::S_WREC;
            end
         end
         fps_pkg::S_WREC: begin
            next_r.cnt = r.cnt - 8'h01;
            if (r.cnt == 8'h01) begin
               next_r.ceN  = 1'b1;
               next_r.dqOe = 1'b0;
               if (r.twoWr && !r.wrIdx) begin
                  next_r.wrIdx = 1'b1;
                  next_r.st    = fps_pkg::S_WSET;
               end else if (r.poll || r.op == fps_pkg::OP_STATUS) begin
                  // after the command status reads follow; a queued suspend or the read-array tail can still write
                  next_r.cnt = fps_pkg::ACC_CYC;
                  next_r.st  = fps_pkg::S_RPUL;
               end else begin
                  if (r.op == fps_pkg::OP_RESUME) begin
                     next_r.suspended = 1'b0;
                  end
                  next_r.busy         = 1'b0;
                  ev[fps_pkg::IRQ_DONE] = 1'b1;
                  next_r.st           = fps_pkg::S_IDLE;
               end
            end
         end
         fps_pkg::S_RPUL: begin
            next_r.ceN    = 1'b0;
            next_r.oeN    = 1'b0;
            next_r.flAddr = r.addr;
            next_r.cnt    = r.cnt - 8'h01;
            if (r.cnt <= 8'h01) begin
               // sampled late enough to cover access time and sync delay
               next_r.rdData = dqSync;
               if (r.op != fps_pkg::OP_READ) begin
                  next_r.lastStat = dqSync[7:0];
               end
               next_r.ceN = 1'b1;
               next_r.oeN = 1'b1;
               next_r.cnt = fps_pkg::REC_CYC;
               next_r.st  = fps_pkg::S_RGAP;
            end
         end
         fps_pkg::S_RGAP: begin
            next_r.cnt = r.cnt - 8'h01;
            if (r.cnt == 8'h01) begin
               if (r.poll && !sb[fps_pkg::MACHINE_READY_FLAG]) begin
                  // strobe again: status only refreshes on a new falling edge
                  next_r.cnt = fps_pkg::ACC_CYC;
                  next_r.st  = fps_pkg::S_RPUL;
                  if (r.suspReq) begin
                     next_r.op      = fps_pkg::OP_SUSPEND;
                     next_r.word0   = {8'h00, fps_pkg::CMD_SUSPEND};
                     next_r.twoWr   = 1'b0;
                     next_r.wrIdx   = 1'b0;
                     next_r.tail    = 1'b1;
                     next_r.suspReq = 1'b0;
                     next_r.st      = fps_pkg::S_WSET;
                  end
               end else begin
                  next_r.st   = fps_pkg::S_IDLE;
                  next_r.suspReq = 1'b0;
                  next_r.busy = 1'b0;
                  ev[fps_pkg::IRQ_DONE] = 1'b1;
                  if (r.poll && r.op != fps_pkg::OP_SUSPEND) begin
                     // flags only accumulate, so deferred checks stay valid
                     next_r.supplyLow = r.supplyLow | sb[fps_pkg::SUPPLY_LOW_FLAG];
                     next_r.progFail  = r.progFail | sb[fps_pkg::PROGRAM_FAIL_FLAG];
                     next_r.eraseFail = r.eraseFail | sb[fps_pkg::ERASE_FAIL_FLAG];
                     if (r.op == fps_pkg::OP_ERASE) begin
                        next_r.seqErr = r.seqErr | (sb[fps_pkg::PROGRAM_FAIL_FLAG] &
                                                    sb[fps_pkg::ERASE_FAIL_FLAG]);
                     end
                     ev[fps_pkg::IRQ_ERROR] = sb[fps_pkg::SUPPLY_LOW_FLAG] | sb[fps_pkg::PROGRAM_FAIL_FLAG]
                                            | sb[fps_pkg::ERASE_FAIL_FLAG];
                  end
                  if (r.op == fps_pkg::OP_SUSPEND) begin
                     next_r.suspended = sb[fps_pkg::ERASE_SUSPENDED_FLAG];
                     next_r.suspAddr  = r.addr;
                     if (r.tail && sb[fps_pkg::ERASE_SUSPENDED_FLAG]) begin
                        // suspended: go straight to read array
                        next_r.word0 = {2{fps_pkg::CMD_READ_ARRAY}};
                        next_r.poll  = 1'b0;
                        next_r.tail  = 1'b0;
                        next_r.busy  = 1'b1;
                        ev[fps_pkg::IRQ_DONE] = 1'b0;
                        next_r.st    = fps_pkg::S_WSET;
                     end
                  end
               end
            end
         end
      endcase
      // interrupts: set wins over write-one-to-clear
      if (apbAcc && pwrite && paddr == fps_pkg::ADDR_IRQ_STAT) begin
         next_r.irqStat = r.irqStat & ~pwdata[2:0];
      end
      next_r.irqStat = next_r.irqStat | ev;
      next_r.irq     = |(next_r.irqStat & next_r.irqMask);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r     <= '0;
         r.st  <= fps_pkg::S_IDLE;
         r.ceN <= 1'b1;
         r.oeN <= 1'b1;
         r.weN <= 1'b1;
         r.rpN <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign prdata  = r.prdata;
   assign pready  = r.pready;
   assign pslverr = r.pslverr;
   assign irq     = r.irq;
   assign flAddr  = r.flAddr;
   assign flDqOut = r.dqOut;
   assign flDqOe  = r.dqOe;
   assign flCeN   = r.ceN;
   assign flOeN   = r.oeN;
   assign flWeN   = r.weN;
   assign flByteN = r.wordMode;
   assign flRpN   = r.rpN;

   // ***********************************************************
   // checks
   // ***********************************************************
   sequence seq_gap_restrobe;
      r.st == fps_pkg::S_RGAP ##1 r.st == fps_pkg::S_RPUL;
   endsequence

   a_prog_setup_code: assert property (@(posedge clk) disable iff (!rst_n)
      (r.st == fps_pkg::S_WPUL && r.op == fps_pkg::OP_PROG && !r.wrIdx) |->
      (r.dqOut[7:0] == fps_pkg::CMD_PROG_SETUP || r.dqOut[7:0] == fps_pkg::CMD_PROG_SETUP_ALT))
      else $error("bad program setup code");
   a_prog_data_word: assert property (@(posedge clk) disable iff (!rst_n)
      (r.st == fps_pkg::S_WPUL && r.op == fps_pkg::OP_PROG && r.wrIdx) |-> (r.dqOut == r.word1 && !r.weN))
      else $error("program data not driven");
   a_status_restrobe: assert property (@(posedge clk) disable iff (!rst_n)
      seq_gap_restrobe |-> $past(r.oeN) && $past(r.ceN))
      else $error("status poll without new strobe");
   a_ready_before_done: assert property (@(posedge clk) disable iff (!rst_n)
      ($fell(r.busy) && r.poll) |-> r.lastStat[fps_pkg::MACHINE_READY_FLAG])
      else $error("finished before ready bit");
   a_array_code: assert property (@(posedge clk) disable iff (!rst_n)
      (r.st == fps_pkg::S_WPUL && r.op == fps_pkg::OP_ARRAY) |-> r.dqOut[7:0] == fps_pkg::CMD_READ_ARRAY)
      else $error("read array code wrong");
   a_supply_block: assert property (@(posedge clk) disable iff (!rst_n)
      (goReq && r.supplyLow && reqOp == fps_pkg::OP_ERASE) |=> r.st == fps_pkg::S_IDLE [*2])
      else $error("erase started with supply low");
   a_erase_pair: assert property (@(posedge clk) disable iff (!rst_n)
      (r.st == fps_pkg::S_WPUL && r.op == fps_pkg::OP_ERASE) |->
      r.dqOut[7:0] == (r.wrIdx ? fps_pkg::CMD_CONFIRM : fps_pkg::CMD_ERASE_SETUP))
      else $error("erase sequence code wrong");
   a_suspend_report: assert property (@(posedge clk) disable iff (!rst_n)
      (r.st == fps_pkg::S_RGAP && r.cnt == 8'h01 && r.op == fps_pkg::OP_SUSPEND &&
       r.lastStat[fps_pkg::MACHINE_READY_FLAG]) |=> r.suspended == $past(r.lastStat[fps_pkg::ERASE_SUSPENDED_FLAG]))
      else $error("suspended flag not taken");
   a_poll_only_reads: assert property (@(posedge clk) disable iff (!rst_n)
      (r.st == fps_pkg::S_RPUL && r.op == fps_pkg::OP_PROG) |=> r.weN && r.st != fps_pkg::S_WSET)
      else $error("write during program poll");
   a_suspend_filter: assert property (@(posedge clk) disable iff (!rst_n)
      (goReq && r.suspended && reqOp == fps_pkg::OP_PROG) |=> r.irqStat[fps_pkg::IRQ_REFUSED] && r.op == $past(r.op))
      else $error("program accepted while suspended");
   a_clear_flags: assert property (@(posedge clk) disable iff (!rst_n)
      (goReq && !refuse && reqOp == fps_pkg::OP_CLEAR) |=> !r.progFail && !r.eraseFail && !r.supplyLow)
      else $error("clear did not reset flags");
endmodule // fps_sequencer

// ==== fps_pkg.sv ====
// shared constants and types for the flash program/erase sequencer
package fps_pkg;
   // ***********************************************************
   // register map (apb byte offsets)
   // ***********************************************************
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_ADDR     = 8'h04;
   localparam logic [7:0] ADDR_DATA     = 8'h08;
   localparam logic [7:0] ADDR_STATUS   = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
   localparam logic [7:0] ADDR_CFG      = 8'h18;
   // ctrl fields
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_ALT    = 3;
   // status register fields of the controller
   localparam int ST_BUSY      = 0;
   localparam int ST_PROG_FAIL = 1;
   localparam int ST_ERASE_FAIL = 2;
   localparam int ST_SUPPLY_LOW = 3;
   localparam int ST_SUSPENDED  = 4;
   localparam int ST_SEQ_ERR    = 5;
   localparam int ST_LAST_LSB   = 8;
   // interrupt bits
   localparam int IRQ_DONE    = 0;
   localparam int IRQ_ERROR   = 1;
   localparam int IRQ_REFUSED = 2;
   localparam int IRQ_W       = 3;
   // cfg fields
   localparam int CFG_WORD  = 0;
   localparam int CFG_PDOWN = 1;
   // ***********************************************************
   // device status register bits
   // ***********************************************************
   localparam int MACHINE_READY_FLAG   = 7;
   localparam int ERASE_SUSPENDED_FLAG = 6;
   localparam int ERASE_FAIL_FLAG      = 5;
   localparam int PROGRAM_FAIL_FLAG    = 4;
   localparam int SUPPLY_LOW_FLAG      = 3;
   // ***********************************************************
   // device command codes
   // ***********************************************************
   localparam logic [7:0] CMD_PROG_SETUP     = 8'h40;
   localparam logic [7:0] CMD_PROG_SETUP_ALT = 8'h10;
   localparam logic [7:0] CMD_ERASE_SETUP    = 8'h20;
   localparam logic [7:0] CMD_CONFIRM        = 8'hD0;
   localparam logic [7:0] CMD_SUSPEND        = 8'hB0;
   localparam logic [7:0] CMD_READ_ARRAY     = 8'hFF;
   localparam logic [7:0] CMD_READ_STATUS    = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS   = 8'h50;
   // ***********************************************************
   // operations requested through ctrl
   // ***********************************************************
   localparam logic [2:0] OP_READ    = 3'h0;
   localparam logic [2:0] OP_PROG    = 3'h1;
   localparam logic [2:0] OP_ERASE   = 3'h2;
   localparam logic [2:0] OP_SUSPEND = 3'h3;
   localparam logic [2:0] OP_RESUME  = 3'h4;
   localparam logic [2:0] OP_CLEAR   = 3'h5;
   localparam logic [2:0] OP_ARRAY   = 3'h6;
   localparam logic [2:0] OP_STATUS  = 3'h7;
   // upper address bits compared to keep reads off a suspended block
   localparam int BLOCK_LSB = 13;
   // ***********************************************************
   // timing
   // ***********************************************************
   localparam int CLK_NS   = 4;
   localparam int T_WP_NS  = 60;
   localparam int T_ACC_NS = 160;
   localparam int T_REC_NS = 40;
   localparam int SYNC_LAT = 3;
   localparam logic [7:0] WP_CYC  = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT);
   localparam logic [7:0] REC_CYC = 8'((T_REC_NS + CLK_NS - 1) / CLK_NS);
   // ***********************************************************
   // sequencer state
   // ***********************************************************
   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_WSET = 6'h02,
      S_WPUL = 6'h04,
      S_WREC = 6'h08,
      S_RPUL = 6'h10,
      S_RGAP = 6'h20
   } fps_state_type;
endpackage

// ==== fps_pin_sync.sv ====
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module fps_pin_sync #(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] pinIn,
   output logic      [W-1:0] pinOut
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] filt;
   } fps_sync_type;
   fps_sync_type r;
   fps_sync_type next_r;

   // only s2 looks at s1; the filter compares the later stages
   always_comb begin
      next_r    = r;
      next_r.s1 = pinIn;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      for (int i = 0; i < W; i++) begin
         if (r.s2[i] == r.s3[i]) begin
            next_r.filt[i] = r.s3[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign pinOut = r.filt;
endmodule // fps_pin_sync

// ==== fps_flash_model.sv ====
// behavioural flash device on the far side of the sequencer
`timescale 1ns/1ps
module fps_flash_model (
   input  wire logic        clk,
   input  wire logic [16:0] addr,
   input  wire logic [15:0] dq,
   input  wire logic        ceN,
   input  wire logic        oeN,
   input  wire logic        weN,
   input  wire logic        failOp,
   input  wire logic        lowVpp,
   output logic      [15:0] dqIn
);
   logic [7:0]  st = 8'h00;
   logic [1:0]  pend = 2'h0;
   logic        stat = 1'b0;
   logic        er = 1'b0;
   logic        weQ = 1'b1;
   int          cnt = 0;
   logic [15:0] rd;
   wire  [7:0]  c = dq[7:0];
   // fresh contents on every strobe; released bus shows inverse
   assign rd = stat ? {8'h00, cnt == 0 || st[6], st[6:0]} : addr[15:0];
   assign dqIn = (!ceN && !oeN) ? rd : ~rd;
   always @(posedge clk) begin
      weQ <= weN;
      if (cnt > 0 && !st[6]) cnt <= cnt - 1;
      if (weN && !weQ && !ceN) begin
         if (pend == 2'h1) begin
            cnt <= 100;
            er <= 1'b0;
            st[4] <= st[4] | failOp;
            st[3] <= st[3] | lowVpp;
            pend <= 2'h0;
         end else if (pend == 2'h2) begin
            if (c == fps_pkg::CMD_CONFIRM) cnt <= 400;
            if (c == fps_pkg::CMD_CONFIRM) st[5] <= st[5] | failOp;
            er <= 1'b1;
            pend <= 2'h0;
         end else if (cnt > 0 && !st[6]) begin
            if (er && c == fps_pkg::CMD_SUSPEND) st[6] <= 1'b1;
         end else if (st[6]) begin
            if (c == fps_pkg::CMD_CONFIRM) st[6] <= 1'b0;
            if (c == fps_pkg::CMD_READ_ARRAY) stat <= 1'b0;
            if (c == fps_pkg::CMD_READ_STATUS) stat <= 1'b1;
         end else begin
            if (c == fps_pkg::CMD_PROG_SETUP || c == fps_pkg::CMD_PROG_SETUP_ALT) pend <= 2'h1;
            if (c == fps_pkg::CMD_ERASE_SETUP) pend <= 2'h2;
            if (c == fps_pkg::CMD_READ_ARRAY) stat <= 1'b0;
            else stat <= 1'b1;
            if (c == fps_pkg::CMD_CLEAR_STATUS) st[5:3] <= 3'h0;
         end
      end
   end
endmodule // fps_flash_model

// ==== tb_top.sv ====
// self-checking bench for the sequencer and its flash model
`timescale 1ns/1ps
module tb_top;
   logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, failOp = 0, lowVpp = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r, d;
   logic        pready, pslverr, irq, flDqOe, flCeN, flOeN, flWeN, flByteN, flRpN;
   logic [16:0] flAddr;
   logic [15:0] flDqOut, flDqIn;
   logic [64:0] q[$], e;
   int          error_cnt = 0, total_checks = 0, seed = 26390, i;
   fps_sequencer DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .flAddr(flAddr), .flDqOut(flDqOut), .flDqOe(flDqOe), .flDqIn(flDqIn), .flCeN(flCeN),
      .flOeN(flOeN), .flWeN(flWeN), .flByteN(flByteN), .flRpN(flRpN));
   fps_flash_model fm (.clk(clk), .addr(flAddr), .dq(flDqOut), .ceN(flCeN), .oeN(flOeN), .weN(flWeN),
      .failOp(failOp), .lowVpp(lowVpp), .dqIn(flDqIn));
   initial forever #2 clk = ~clk;
   // ***********************************************************
   // bus tasks
   // ***********************************************************
   task automatic fl(input string s);
      error_cnt++;
      $display("[FAIL] %0t %s", $time, s);
   endtask
   task automatic ck(input logic ok);
      total_checks++;
      if (ok !== 1'b1) fl("pin mismatch");
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] v, input logic [31:0] m,
                      input logic ee);
      int k;
      k = 0;
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= v;
      @(posedge clk);
      penable <= 1'b1;
      if (!w) q.push_back({ee, m, v});
      do @(posedge clk); while (pready !== 1'b1 && ++k < 50);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) begin
         fl("no ready");
         summarize();
      end
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      apb(a, 1'b1, v, 32'h0, 1'b0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      apb(a, 1'b0, v, m, 1'b0);
   endtask
   // bounded wait for busy to drop
   task automatic op(input logic [2:0] o, input logic alt);
      int k;
      k = 0;
      wr(fps_pkg::ADDR_CTRL, {28'h0, alt, o});
      do rd(fps_pkg::ADDR_STATUS, 32'h0, 32'h0); while (r[0] !== 1'b0 && ++k < 400);
      if (k >= 400) begin
         fl("busy hang");
         summarize();
      end
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk) if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
      e = q.pop_front();
      total_checks++;
      if ((prdata & e[63:32]) !== e[31:0] || pslverr !== e[64]) fl("read mismatch");
   end
   initial begin
      repeat (100000) @(posedge clk);
      fl("timeout");
      summarize();
   end
   // ***********************************************************
   // scenarios
   // ***********************************************************
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(fps_pkg::ADDR_STATUS, 32'h3F, 32'h0);
      apb(8'h1C, 1'b0, 32'h0, 32'h0, 1'b1);
      wr(fps_pkg::ADDR_CFG, 32'h1);
      wr(fps_pkg::ADDR_IRQ_MASK, 32'h7);
      for (i = 0; i < 2; i++) begin
         wr(fps_pkg::ADDR_ADDR, $random(seed) & 32'h1FFFF);
         wr(fps_pkg::ADDR_DATA, $random(seed) & 32'hFFFF);
         failOp <= i[0];
         op(fps_pkg::OP_PROG, i[0]);
         rd(fps_pkg::ADDR_STATUS, 32'h8003, {16'h0, 1'b1, 13'h0, i[0], 1'b0});
      end
      failOp <= 1'b0;
      op(fps_pkg::OP_PROG, 1'b0);
      rd(fps_pkg::ADDR_STATUS, 32'h2, 32'h2);
      failOp <= 1'b1;
      op(fps_pkg::OP_ERASE, 1'b0);
      rd(fps_pkg::ADDR_STATUS, 32'h26, 32'h26);
      rd(fps_pkg::ADDR_IRQ_STAT, 32'h5, 32'h1);
      ck(irq === 1'b1);
      wr(fps_pkg::ADDR_IRQ_MASK, 32'h0);
      ck(irq === 1'b0);
      wr(fps_pkg::ADDR_IRQ_MASK, 32'h7);
      wr(fps_pkg::ADDR_IRQ_STAT, 32'h7);
      ck(irq === 1'b0);
      op(fps_pkg::OP_CLEAR, 1'b0);
      rd(fps_pkg::ADDR_STATUS, 32'h2E, 32'h0);
      failOp <= 1'b1;
      op(fps_pkg::OP_ERASE, 1'b0);
      failOp <= 1'b0;
      op(fps_pkg::OP_ERASE, 1'b0);
      rd(fps_pkg::ADDR_STATUS, 32'h24, 32'h4);
      op(fps_pkg::OP_CLEAR, 1'b0);
      lowVpp <= 1'b1;
      op(fps_pkg::OP_PROG, 1'b0);
      lowVpp <= 1'b0;
      rd(fps_pkg::ADDR_STATUS, 32'h8, 32'h8);
      wr(fps_pkg::ADDR_IRQ_STAT, 32'h7);
      op(fps_pkg::OP_PROG, 1'b0);
      op(fps_pkg::OP_ERASE, 1'b0);
      rd(fps_pkg::ADDR_IRQ_STAT, 32'h4, 32'h4);
      op(fps_pkg::OP_CLEAR, 1'b0);
      d = $random(seed) & 32'h1FFFF;
      wr(fps_pkg::ADDR_ADDR, d);
      op(fps_pkg::OP_ARRAY, 1'b0);
      op(fps_pkg::OP_READ, 1'b0);
      rd(fps_pkg::ADDR_DATA, 32'hFFFF, d & 32'hFFFF);
      op(fps_pkg::OP_STATUS, 1'b0);
      rd(fps_pkg::ADDR_STATUS, 32'h8000, 32'h8000);
      wr(fps_pkg::ADDR_CTRL, {29'h0, fps_pkg::OP_ERASE});
      op(fps_pkg::OP_SUSPEND, 1'b0);
      rd(fps_pkg::ADDR_STATUS, 32'h10, 32'h10);
      wr(fps_pkg::ADDR_IRQ_STAT, 32'h7);
      op(fps_pkg::OP_PROG, 1'b0);
      rd(fps_pkg::ADDR_IRQ_STAT, 32'h4, 32'h4);
      wr(fps_pkg::ADDR_IRQ_STAT, 32'h7);
      op(fps_pkg::OP_READ, 1'b0);
      rd(fps_pkg::ADDR_IRQ_STAT, 32'h4, 32'h4);
      op(fps_pkg::OP_RESUME, 1'b0);
      rd(fps_pkg::ADDR_STATUS, 32'h10, 32'h0);
      summarize();
   end
endmodule // tb_top
